/* hw/dew_debug_write.sv */
// Debug enclave write leaf: checking, write sequencing and register file
`timescale 1ns/100ps
`include "dew_defines.svh"

module dew_debug_write #(
   parameter int          VADDR_BITS = 48,
   parameter logic [11:0] TCS_FLAGS_OFFSET = 12'h008,
   parameter logic [63:0] PAGE_NOT_DEBUGGABLE_CODE = 64'h0000_0000_0000_0020
) (
   input  wire logic                      clk_sys,
   input  wire logic                      reset,
   input  wire logic [5:0]                avs_address,
   input  wire logic                      avs_read,
   input  wire logic                      avs_write,
   input  wire logic [31:0]               avs_writedata,
   input  wire logic [3:0]                avs_byteenable,
   output logic      [31:0]               avs_readdata,
   output logic                           avs_waitrequest,
   output logic                           pcm_req,
   output logic      [63:0]               pcm_addr,
   input  wire logic                      pcm_ack,
   input  wire dew_pkg::dew_pcm_resp_type pcm_resp,
   output logic                           owner_req,
   output logic      [63:0]               owner_ref,
   input  wire logic                      owner_ack,
   input  wire logic                      owner_debug,
   output logic                           mem_wr_valid,
   output dew_pkg::dew_mem_wr_type        mem_wr,
   input  wire logic                      mem_wr_ready,
   output logic                           op_done,
   output logic                           fault_gp,
   output logic                           fault_pf
);

   typedef enum logic [2:0] {
      ST_IDLE, ST_CHECK, ST_MAP, ST_EVAL, ST_OWNER, ST_WRITE
   } dew_state_type;

   dew_state_type            state_q;
   logic [31:0]              ctrl_q;
   logic [31:0]              leaf_q;
   logic [63:0]              tgt_q;
   logic [63:0]              data_q;
   logic [31:0]              ds_limit_q;
   logic [5:0]               flags_q;
   logic [63:0]              result_q;
   logic [63:0]              faddr_q;
   dew_pkg::dew_fault_type   fault_q;
   dew_pkg::dew_pcm_resp_type map_q;
   logic                     done_q;
   logic                     rd_ack_q;
   logic [31:0]              rdata_q;
   logic                     start;
   logic                     wide;
   logic                     local_gp;
   logic                     end_gp;
   logic                     end_pf;
   logic                     end_err;
   logic                     end_ok;
   logic                     end_leaf;
   logic                     map_gp;
   logic                     map_pf;
   logic [32:0]              last_byte;
   logic [31:0]              status_wr;

   // ----------------------------------------------------------------------------
   // Helper functions
   // ----------------------------------------------------------------------------
   // Byte-lane merge, used for every writable word
   function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  be);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[8*i +: 8] = new_v[8*i +: 8];
         end
      end
      return r;
   endfunction : be_merge

   // Upper address bits must all copy the top implemented bit
   function automatic logic is_canonical(input logic [63:0] a);
      return (&a[63:VADDR_BITS-1]) | ~(|a[63:VADDR_BITS-1]);
   endfunction : is_canonical

   // ----------------------------------------------------------------------------
   // Combinational decisions
   // ----------------------------------------------------------------------------
   // Start is a write of 1 to the start bit; ignored while an operation runs
   assign start = avs_write && avs_address == `DEW_OFF_CTRL && avs_byteenable[0]
                  && avs_writedata[`DEW_CTRL_START] && state_q == ST_IDLE;
   assign wide  = ctrl_q[`DEW_CTRL_LMA] & ctrl_q[`DEW_CTRL_CSL];
   assign last_byte = {1'b0, tgt_q[31:0]} + `DEW_WORD4_LAST;

   // Status word as software would leave it after a byte-lane write
   // Merged here because a select on a function result is not legal
   assign status_wr = be_merge({26'h0, flags_q} << `DEW_ST_FLAG_LO, avs_writedata,
                               avs_byteenable);

   // Register-level checks, in order of precedence
   always_comb begin
      local_gp = 1'b0;
      if (ctrl_q[`DEW_CTRL_CPL_HI:`DEW_CTRL_CPL_LO] != 2'h0) begin
         local_gp = 1'b1;
      end else if (ctrl_q[`DEW_CTRL_DSUNUSE] || !ctrl_q[`DEW_CTRL_DSWRITE]) begin
         local_gp = 1'b1;
      end else if (!wide && last_byte > {1'b0, ds_limit_q}) begin
         local_gp = 1'b1;
      end else if (wide && !is_canonical(tgt_q)) begin
         local_gp = 1'b1;
      end else if (wide && (tgt_q[2:0] & `DEW_ALIGN8_MASK) != 3'h0) begin
         local_gp = 1'b1;
      end else if (!wide && (tgt_q[1:0] & `DEW_ALIGN4_MASK) != 2'h0) begin
         local_gp = 1'b1;
      end
   end

   // Map entry checks; access permissions are deliberately not looked at
   always_comb begin
      map_pf = 1'b0;
      map_gp = 1'b0;
      if (!map_q.resident) begin
         map_pf = 1'b1;
      end else if (map_q.busy_modify) begin
         map_gp = 1'b1;
      end else if (!map_q.valid) begin
         map_pf = 1'b1;
      end else if (map_q.ptype != `DEW_PT_REGULAR && map_q.ptype != `DEW_PT_THREAD
                   && map_q.ptype != `DEW_PAGE_TYPE_SHADOW_STACK_FIRST
                   && map_q.ptype != `DEW_PAGE_TYPE_SHADOW_STACK_REST) begin
         map_pf = 1'b1;
      end else if (!(map_q.pending || map_q.modified)
                   && map_q.ptype == `DEW_PT_THREAD
                   && (tgt_q[11:0] & `DEW_TCS_MASK)
                      != (TCS_FLAGS_OFFSET & `DEW_TCS_MASK)) begin
         map_gp = 1'b1;
      end
   end

   // Ways an operation can end in this cycle
   assign end_leaf = start && leaf_q != `DEW_LEAF_DEBUG_WR;
   assign end_gp   = (state_q == ST_CHECK && local_gp)
                     || (state_q == ST_EVAL && map_gp)
                     || (state_q == ST_OWNER && owner_ack && !owner_debug);
   assign end_pf   = state_q == ST_EVAL && map_pf;
   assign end_err  = state_q == ST_EVAL && !map_pf && !map_gp
                     && (map_q.pending || map_q.modified);
   assign end_ok   = state_q == ST_WRITE && mem_wr_ready;

   // Lookup and write handshakes
   assign pcm_req      = state_q == ST_MAP;
   assign pcm_addr     = tgt_q;
   assign owner_req    = state_q == ST_OWNER;
   assign owner_ref    = map_q.owner_ref;
   assign mem_wr_valid = state_q == ST_WRITE;
   assign mem_wr.addr  = tgt_q;
   assign mem_wr.wide  = wide;
   assign mem_wr.data  = wide ? data_q : {32'h0000_0000, data_q[31:0]};

   // ----------------------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------------------
   // Map answer is latched so that checks see a stable entry
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         state_q <= ST_IDLE;
      end else begin
         unique case (state_q)
            ST_IDLE:  if (start && !end_leaf) state_q <= ST_CHECK;
            ST_CHECK: state_q <= local_gp ? ST_IDLE : ST_MAP;
            ST_MAP:   if (pcm_ack) state_q <= ST_EVAL;
            ST_EVAL:  state_q <= (map_pf || map_gp || end_err) ? ST_IDLE : ST_OWNER;
            ST_OWNER: if (owner_ack) state_q <= owner_debug ? ST_WRITE : ST_IDLE;
            ST_WRITE: if (mem_wr_ready) state_q <= ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         map_q <= '0;
      end else if (state_q == ST_MAP && pcm_ack) begin
         map_q <= pcm_resp;
      end
   end

   // ----------------------------------------------------------------------------
   // Completion: result, flags, fault report
   // ----------------------------------------------------------------------------
   // Hardware completion wins over a software write of the flags in the same cycle
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         flags_q  <= 6'h00;
         result_q <= 64'h0000_0000_0000_0000;
      end else if (end_err) begin
         flags_q  <= 6'h01;
         result_q <= PAGE_NOT_DEBUGGABLE_CODE;
      end else if (end_ok) begin
         flags_q  <= 6'h00;
         result_q <= 64'h0000_0000_0000_0000;
      end else if (avs_write && avs_address == `DEW_OFF_STATUS) begin
         flags_q  <= status_wr[`DEW_ST_FLAG_HI:`DEW_ST_FLAG_LO];
      end
   end

   // Faults leave result and flags alone and report the class
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         fault_q <= dew_pkg::DEW_FAULT_NONE;
         faddr_q <= 64'h0000_0000_0000_0000;
         done_q  <= 1'b0;
      end else begin
         done_q <= end_gp || end_pf || end_err || end_ok || end_leaf;
         if (start) begin
            fault_q <= end_leaf ? dew_pkg::DEW_FAULT_LEAF : dew_pkg::DEW_FAULT_NONE;
         end else if (end_gp) begin
            fault_q <= dew_pkg::DEW_FAULT_GP;
         end else if (end_pf) begin
            fault_q <= dew_pkg::DEW_FAULT_PF;
            faddr_q <= tgt_q;
         end
      end
   end

   assign op_done  = done_q;
   assign fault_gp = fault_q == dew_pkg::DEW_FAULT_GP;
   assign fault_pf = fault_q == dew_pkg::DEW_FAULT_PF;

   // ----------------------------------------------------------------------------
   // Register file over Avalon-MM
   // ----------------------------------------------------------------------------
   // Operands are frozen while an operation runs so checks stay consistent
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         ctrl_q     <= `DEW_CTRL_RESET;
         leaf_q     <= 32'h0000_0000;
         tgt_q      <= 64'h0000_0000_0000_0000;
         data_q     <= 64'h0000_0000_0000_0000;
         ds_limit_q <= `DEW_DS_LIMIT_RESET;
      end else if (avs_write && state_q == ST_IDLE) begin
         unique case (avs_address)
            `DEW_OFF_CTRL: begin
               ctrl_q <= be_merge(ctrl_q, avs_writedata, avs_byteenable)
                         & ~32'h0000_0001;
            end
            `DEW_OFF_LEAF:     leaf_q <= be_merge(leaf_q, avs_writedata, avs_byteenable);
            `DEW_OFF_TGT_LO:   tgt_q[31:0] <= be_merge(tgt_q[31:0], avs_writedata,
                                                       avs_byteenable);
            `DEW_OFF_TGT_HI:   tgt_q[63:32] <= be_merge(tgt_q[63:32], avs_writedata,
                                                        avs_byteenable);
            `DEW_OFF_DATA_LO:  data_q[31:0] <= be_merge(data_q[31:0], avs_writedata,
                                                        avs_byteenable);
            `DEW_OFF_DATA_HI:  data_q[63:32] <= be_merge(data_q[63:32], avs_writedata,
                                                         avs_byteenable);
            `DEW_OFF_DS_LIMIT: ds_limit_q <= be_merge(ds_limit_q, avs_writedata,
                                                      avs_byteenable);
            default: ;
         endcase
      end
   end

   // Reads take one wait cycle so that read data come from a flip-flop
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         rd_ack_q <= 1'b0;
         rdata_q  <= 32'h0000_0000;
      end else begin
         rd_ack_q <= avs_read && !rd_ack_q;
         if (avs_read && !rd_ack_q) begin
            unique case (avs_address)
               `DEW_OFF_CTRL:     rdata_q <= ctrl_q;
               `DEW_OFF_LEAF:     rdata_q <= leaf_q;
               `DEW_OFF_TGT_LO:   rdata_q <= tgt_q[31:0];
               `DEW_OFF_TGT_HI:   rdata_q <= tgt_q[63:32];
               `DEW_OFF_DATA_LO:  rdata_q <= data_q[31:0];
               `DEW_OFF_DATA_HI:  rdata_q <= data_q[63:32];
               `DEW_OFF_DS_LIMIT: rdata_q <= ds_limit_q;
               `DEW_OFF_STATUS: begin
                  rdata_q <= {22'h0, flags_q, fault_q, done_q, state_q != ST_IDLE};
               end
               `DEW_OFF_RES_LO:   rdata_q <= result_q[31:0];
               `DEW_OFF_RES_HI:   rdata_q <= result_q[63:32];
               `DEW_OFF_FADDR_LO: rdata_q <= faddr_q[31:0];
               `DEW_OFF_FADDR_HI: rdata_q <= faddr_q[63:32];
               default:           rdata_q <= 32'h0000_0000;
            endcase
         end
      end
   end

   assign avs_readdata    = rdata_q;
   assign avs_waitrequest = avs_read && !rd_ack_q;

   // ----------------------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset);

   wrong_leaf_a: assert property (start && leaf_q != `DEW_LEAF_DEBUG_WR
      |=> state_q == ST_IDLE && fault_q == dew_pkg::DEW_FAULT_LEAF && op_done)
      else $error("wrong leaf not refused");
   write_size_a: assert property (mem_wr_valid
      |-> mem_wr.wide == (ctrl_q[1] && ctrl_q[2]))
      else $error("write size does not follow mode");
   align_fault_a: assert property (state_q == ST_CHECK && wide
      && tgt_q[2:0] != 3'h0 |=> fault_gp && state_q == ST_IDLE)
      else $error("misaligned wide target not faulted");
   nonres_pf_a: assert property (state_q == ST_EVAL && !map_q.resident
      |=> fault_pf && faddr_q == $past(tgt_q))
      else $error("non-resident target not page faulted");
   busy_gp_a: assert property (state_q == ST_EVAL && map_q.resident
      && map_q.busy_modify |=> fault_gp ##1 !mem_wr_valid)
      else $error("concurrent modifier not faulted");
   invalid_pf_a: assert property (state_q == ST_EVAL && map_q.resident
      && !map_q.busy_modify && !map_q.valid |=> fault_pf)
      else $error("invalid entry not page faulted");
   ptype_pf_a: assert property (mem_wr_valid
      |-> map_q.ptype inside {`DEW_PT_REGULAR, `DEW_PT_THREAD,
                              `DEW_PAGE_TYPE_SHADOW_STACK_FIRST, `DEW_PAGE_TYPE_SHADOW_STACK_REST})
      else $error("write to forbidden page type");
   not_debug_a: assert property (end_err
      |=> flags_q == 6'h01 && result_q == PAGE_NOT_DEBUGGABLE_CODE && !fault_gp)
      else $error("pending page error not reported");
   tcs_offset_a: assert property (mem_wr_valid && map_q.ptype == `DEW_PT_THREAD
      |-> (tgt_q[11:0] & 12'hFF8) == (TCS_FLAGS_OFFSET & 12'hFF8))
      else $error("thread page written away from flags word");
   owner_gp_a: assert property (owner_req && owner_ack && !owner_debug
      |=> fault_gp && !mem_wr_valid)
      else $error("non-debug owner not faulted");
   success_a: assert property (mem_wr_valid && mem_wr_ready
      |=> result_q == 64'h0 && flags_q == 6'h00 && op_done)
      else $error("success not reported");
   priv_gp_a: assert property (state_q == ST_CHECK && ctrl_q[5:4] != 2'h0
      |=> fault_gp ##1 !mem_wr_valid)
      else $error("privileged level above zero not faulted");
   canon_gp_a: assert property (state_q == ST_CHECK && wide
      && !is_canonical(tgt_q) |=> fault_gp)
      else $error("non-canonical target not faulted");
   seg_gp_a: assert property (state_q == ST_CHECK && ctrl_q[8]
      |=> fault_gp)
      else $error("unusable data segment not faulted");

   ok_write_c: cover property (mem_wr_valid && mem_wr_ready && mem_wr.wide);
   narrow_write_c: cover property (mem_wr_valid && mem_wr_ready && !mem_wr.wide);
   pend_err_c: cover property (end_err);
   owner_fault_c: cover property (owner_ack && !owner_debug);

endmodule : dew_debug_write

/* hw/dew_defines.svh */
// Register offsets, field positions, reset values and codes of the debug write block
`ifndef DEW_DEFINES_SVH
`define DEW_DEFINES_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define DEW_OFF_CTRL      6'h00
`define DEW_OFF_LEAF      6'h04
`define DEW_OFF_TGT_LO    6'h08
`define DEW_OFF_TGT_HI    6'h0C
`define DEW_OFF_DATA_LO   6'h10
`define DEW_OFF_DATA_HI   6'h14
`define DEW_OFF_DS_LIMIT  6'h18
`define DEW_OFF_STATUS    6'h1C
`define DEW_OFF_RES_LO    6'h20
`define DEW_OFF_RES_HI    6'h24
`define DEW_OFF_FADDR_LO  6'h28
`define DEW_OFF_FADDR_HI  6'h2C

// ----------------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------------
`define DEW_CTRL_START    0
`define DEW_CTRL_LMA      1
`define DEW_CTRL_CSL      2
`define DEW_CTRL_CPL_LO   4
`define DEW_CTRL_CPL_HI   5
`define DEW_CTRL_DSUNUSE  8
`define DEW_CTRL_DSWRITE  9
`define DEW_CTRL_RESET    32'h0000_0200

// ----------------------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------------------
`define DEW_ST_BUSY       0
`define DEW_ST_DONE       1
`define DEW_ST_FAULT_LO   2
`define DEW_ST_FAULT_HI   3
`define DEW_ST_FLAG_LO    4
`define DEW_ST_FLAG_HI    9

// Flag vector positions: zero, carry, parity, aux carry, overflow, sign
`define DEW_FL_ZERO       0
`define DEW_FLAGS_CLEAR   6'h3E

// ----------------------------------------------------------------------------
// Codes and reset values
// ----------------------------------------------------------------------------
`define DEW_LEAF_DEBUG_WR 32'h0000_0005
`define DEW_PT_CTRL_STRUCT 3'h0
`define DEW_PT_REGULAR    3'h1
`define DEW_PT_THREAD     3'h2
`define DEW_PT_VERSION    3'h3
`define DEW_PAGE_TYPE_SHADOW_STACK_FIRST   3'h5
`define DEW_PAGE_TYPE_SHADOW_STACK_REST    3'h6
`define DEW_TCS_MASK      12'hFF8
`define DEW_ALIGN8_MASK   3'h7
`define DEW_ALIGN4_MASK   2'h3
`define DEW_DS_LIMIT_RESET 32'hFFFF_FFFF
`define DEW_WORD4_LAST    33'h0_0000_0003

`endif

/* hw/dew_pkg.sv */
// Types shared by the debug enclave write block
package dew_pkg;

   // Fault classes reported after an operation
   typedef enum logic [1:0] {
      DEW_FAULT_NONE,
      DEW_FAULT_GP,
      DEW_FAULT_PF,
      DEW_FAULT_LEAF
   } dew_fault_type;

   // Answer of the page cache map lookup
   typedef struct packed {
      logic        resident;
      logic        valid;
      logic [2:0]  ptype;
      logic        pending;
      logic        modified;
      logic        busy_modify;
      logic [63:0] owner_ref;
   } dew_pcm_resp_type;

   // Write towards protected memory
   typedef struct packed {
      logic [63:0] addr;
      logic [63:0] data;
      logic        wide;
   } dew_mem_wr_type;

endpackage : dew_pkg

/* testbench/dew_far_model.sv */
// Far-side model: page map, owner structure and protected memory
`timescale 1ns/100ps
module dew_far_model (
   input  wire logic                      clk_sys,
   input  wire logic                      reset,
   input  wire logic                      pcm_req,
   output logic                           pcm_ack,
   output dew_pkg::dew_pcm_resp_type      pcm_resp,
   input  wire logic                      owner_req,
   input  wire logic [63:0]               owner_ref,
   output logic                           owner_ack,
   output logic                           owner_debug,
   input  wire logic                      mem_wr_valid,
   output logic                           mem_wr_ready,
   input  wire dew_pkg::dew_pcm_resp_type cfg_resp,
   input  wire logic                      cfg_debug,
   input  wire logic                      cfg_slow
);
   logic [1:0] wait_q;
   logic       go;
   // One delay counter serves all requests; only one is open at a time
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) wait_q <= 2'h0;
      else if ((pcm_req | owner_req | mem_wr_valid) & ~go) wait_q <= wait_q + 2'h1;
      else wait_q <= 2'h0;
   end
   assign go = cfg_slow ? (wait_q == 2'h3) : 1'b1;
   assign pcm_ack = pcm_req & go;
   // Answer lines are scrambled outside the answer cycle
   assign pcm_resp = pcm_ack ? cfg_resp : ~cfg_resp;
   assign owner_ack = owner_req & go;
   // Debug bit only for the owner that the map entry names
   assign owner_debug = (owner_ack & (owner_ref === cfg_resp.owner_ref)) ? cfg_debug
                                                                         : ~cfg_debug;
   assign mem_wr_ready = mem_wr_valid & go;
endmodule : dew_far_model

/* testbench/testbench.sv */
// Self-checking bench for the debug enclave write block
`timescale 1ns/100ps
`include "dew_defines.svh"
module testbench;
   localparam logic [63:0] NOT_DBG = 64'h0000_0000_0000_0020;
   localparam logic [63:0] DATA    = 64'hA5A5_0F0F_1234_5678;
   localparam logic [63:0] TW      = 64'h0000_1234_5678_9AB8;
   localparam logic [31:0] W       = 32'h0000_0207;
   localparam logic [31:0] N       = 32'h0000_0203;
   localparam logic [31:0] L       = `DEW_LEAF_DEBUG_WR;
   logic                      clk_sys = 1'b0;
   logic                      reset = 1'b1;
   logic [5:0]                avs_address = 6'h00;
   logic                      avs_read = 1'b0;
   logic                      avs_write = 1'b0;
   logic [31:0]               avs_writedata = 32'h0000_0000;
   logic [31:0]               avs_readdata, rdq, lo;
   logic                      avs_waitrequest, pcm_req, pcm_ack, owner_req, owner_ack;
   logic                      owner_debug, mem_wr_valid, mem_wr_ready, op_done, fault_gp, fault_pf;
   logic [63:0]               owner_ref, pcm_addr, pa;
   dew_pkg::dew_pcm_resp_type pcm_resp;
   dew_pkg::dew_pcm_resp_type cfg_resp = '0;
   logic                      cfg_debug = 1'b1;
   logic                      cfg_slow = 1'b0;
   dew_pkg::dew_mem_wr_type   mem_wr, lw;
   int                        miscompares = 0, checks_done = 0, done_cnt = 0, wcnt = 0;
   logic [7:0]                bad [4] = '{8'hC0, 8'hD8, 8'hE0, 8'hF8};

   dew_debug_write #(.PAGE_NOT_DEBUGGABLE_CODE(NOT_DBG)) dew_debug_write_i (
      .clk_sys, .reset, .avs_address, .avs_read, .avs_write, .avs_writedata,
      .avs_byteenable(4'hF), .avs_readdata, .avs_waitrequest, .pcm_req, .pcm_addr,
      .pcm_ack, .pcm_resp, .owner_req, .owner_ref, .owner_ack, .owner_debug,
      .mem_wr_valid, .mem_wr, .mem_wr_ready, .op_done, .fault_gp, .fault_pf);
   dew_far_model dew_far_model_i (.clk_sys, .reset, .pcm_req, .pcm_ack, .pcm_resp,
      .owner_req, .owner_ref, .owner_ack, .owner_debug, .mem_wr_valid, .mem_wr_ready,
      .cfg_resp, .cfg_debug, .cfg_slow);

   always #4 clk_sys = ~clk_sys;
   // Count completions and keep the last accepted write
   always @(posedge clk_sys) begin
      if (op_done === 1'b1) done_cnt++;
      if (pcm_req === 1'b1 && pcm_ack === 1'b1) pa = pcm_addr;
      if (mem_wr_valid === 1'b1 && mem_wr_ready === 1'b1) begin
         wcnt++;
         lw = mem_wr;
      end
   end
   // ----------------------------------------------------------------
   // Bus, compare and operation tasks
   // ----------------------------------------------------------------
   task automatic test_done(input bit hung);
      if (hung) miscompares++;
      $display("Checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : test_done
   task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
      checks_done++;
      if (g !== e) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   // Hold the request until waitrequest is seen low at an edge
   task automatic bus(input logic rd, input logic [5:0] a, input logic [31:0] d);
      int n;
      n = 0;
      avs_address <= a;
      avs_writedata <= d;
      avs_read <= rd;
      avs_write <= ~rd;
      do begin
         @(posedge clk_sys);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      rdq = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      if (n >= 50) test_done(1);
      @(posedge clk_sys);
   endtask : bus
   // Flags preset to ones so that clearing shows; faults must leave them
   task automatic op(input logic [31:0] c, input logic [31:0] lf, input logic [63:0] t,
                     input logic [7:0] pm, input logic dbg, input logic [1:0] ef);
      int n0, w0, m;
      logic wr;
      wr = (ef == 2'h0) && (pm[2:1] == 2'h0);
      cfg_resp <= {pm, 64'h0000_0000_0000_7000};
      cfg_debug <= dbg;
      bus(0, `DEW_OFF_LEAF, lf);
      bus(0, `DEW_OFF_TGT_LO, t[31:0]);
      bus(0, `DEW_OFF_TGT_HI, t[63:32]);
      bus(0, `DEW_OFF_STATUS, 32'h0000_03F0);
      n0 = done_cnt;
      w0 = wcnt;
      pa = 64'h0;
      bus(0, `DEW_OFF_CTRL, c);
      for (m = 0; m < 100 && done_cnt == n0; m++) @(posedge clk_sys);
      if (m >= 100) test_done(1);
      bus(1, `DEW_OFF_STATUS, 32'h0000_0000);
      chk("fault", ef, rdq[3:2]);
      chk("flags", (ef != 0) ? 64'h3F : {63'h0, pm[2:1] != 0}, rdq[9:4]);
      chk("pins", {ef == 1, ef == 2}, {fault_gp, fault_pf});
      chk("writes", w0 + wr, wcnt);
      if (ef == 0 || ef == 2) chk("lookup", t, pa);
      if (wr) chk("wr_addr", t, lw.addr);
      if (wr) chk("wr_data", (c[2:1] == 2'h3) ? DATA : {32'h0, DATA[31:0]}, lw.data);
      if (wr) chk("wide", c[2:1] == 2'h3, lw.wide);
      bus(1, (ef == 2) ? `DEW_OFF_FADDR_LO : `DEW_OFF_RES_LO, 32'h0000_0000);
      lo = rdq;
      bus(1, (ef == 2) ? `DEW_OFF_FADDR_HI : `DEW_OFF_RES_HI, 32'h0000_0000);
      if (ef == 2) chk("fault_addr", t, {rdq, lo});
      if (ef == 0) chk("result", wr ? 64'h0 : NOT_DBG, {rdq, lo});
   endtask : op

   initial begin
      repeat (3) @(posedge clk_sys);
      reset <= 1'b0;
      @(posedge clk_sys);
      bus(1, `DEW_OFF_CTRL, 0);
      chk("ctrl_reset", 64'h200, rdq);
      bus(1, 6'h3C, 0);
      chk("unmapped", 64'h0, rdq);
      bus(0, `DEW_OFF_DATA_LO, DATA[31:0]);
      bus(0, `DEW_OFF_DATA_HI, DATA[63:32]);
      op(W, L, TW, 8'hC8, 1, 0);
      op(N, L, 64'h1004, 8'hC8, 1, 0);
      op(32'h0000_0205, L, 64'h1004, 8'hC8, 1, 0);
      op(W, 32'h0000_0006, TW, 8'hC8, 1, 3);
      op(W, L, TW - 4, 8'hC8, 1, 1);
      op(N, L, 64'h1006, 8'hC8, 1, 1);
      cfg_slow <= 1'b1;
      op(W, L, TW, 8'h48, 1, 2);
      op(W, L, TW, 8'hC9, 1, 1);
      op(W, L, TW, 8'h88, 1, 2);
      foreach (bad[i]) op(W, L, TW, bad[i], 1, 2);
      op(W, L, TW, 8'hE8, 1, 0);
      op(W, L, TW, 8'hF0, 1, 0);
      op(W, L, TW, 8'hCC, 1, 0);
      op(W, L, TW, 8'hCA, 1, 0);
      op(W, L, TW + 64'h558, 8'hD0, 1, 1);
      op(N, L, 64'h100C, 8'hD0, 1, 0);
      op(W, L, TW, 8'hC8, 0, 1);
      op(32'h0000_0237, L, TW, 8'hC8, 1, 1);
      op(32'h0000_0307, L, TW, 8'hC8, 1, 1);
      op(32'h0000_0007, L, TW, 8'hC8, 1, 1);
      bus(0, `DEW_OFF_DS_LIMIT, 32'h0000_1007);
      op(N, L, 64'h1004, 8'hC8, 1, 0);
      bus(0, `DEW_OFF_DS_LIMIT, 32'h0000_1006);
      op(N, L, 64'h1004, 8'hC8, 1, 1);
      op(W, L, 64'h0000_8000_0000_0000, 8'hC8, 1, 1);
      op(W, L, 64'hFFFF_8000_0000_0008, 8'hC8, 1, 0);
      test_done(0);
   end
endmodule : testbench
